// ### rtl/pcr_pkg.sv
// shared constants and types for the second phy configuration register
package pcr_pkg;
  // ==========================================================
  // register map
  localparam logic [4:0] PCR_REG_ADDR = 5'h13;
  localparam int REG_W = 16;
  localparam int ADDR_LSB = 11;
  localparam int WIN_LSB = 9;
  localparam int WARN_LSB = 6;
  localparam int FAIL_LSB = 3;
  localparam int JUMBO_BIT = 2;
  localparam int DOZE_LSB = 0;
  localparam logic [2:0] ADDR_HIGH = 3'h1;
  localparam logic [1:0] WIN_RST = 2'h1;
  localparam logic [2:0] WARN_RST = 3'h1;
  localparam logic [2:0] FAIL_RST = 3'h0;
  localparam logic JUMBO_RST = 1'h1;
  localparam logic [1:0] DOZE_RST = 2'h1;
  // ==========================================================
  // management frame
  localparam logic [5:0] PRE_MIN = 6'h20;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [4:0] HDR_LAST = 5'hc;
  localparam logic [4:0] DATA_LAST = 5'hf;
  typedef enum logic [1:0] {SMI_PRE, SMI_HDR, SMI_TA, SMI_DATA} pcr_smi_e;
  // ==========================================================
  // noise ratio monitor
  localparam int SNR_W = 8;
  localparam int ACC_W = 16;
  localparam logic [8:0] WIN_BASE = 9'h20;
  localparam logic [3:0] WIN_SHIFT = 4'h5;
  // class a..g limits, a in the low byte; arbitrary plain levels
  localparam logic [55:0] SNR_LIMITS = 56'h70_60_50_40_30_20_10;
  // ==========================================================
  // doze request timing
  localparam real CLK_KHZ = 100000.0;
  localparam real DOZE_MS_0 = 0.4;
  localparam real DOZE_MS_1 = 1.0;
  localparam real DOZE_MS_2 = 4.0;
  localparam real DOZE_MS_3 = 16.0;
  localparam int DOZE_CYC_0 = int'($floor(DOZE_MS_0 * CLK_KHZ + 0.001));
  localparam int DOZE_CYC_1 = int'($floor(DOZE_MS_1 * CLK_KHZ + 0.001));
  localparam int DOZE_CYC_2 = int'($floor(DOZE_MS_2 * CLK_KHZ + 0.001));
  localparam int DOZE_CYC_3 = int'($floor(DOZE_MS_3 * CLK_KHZ + 0.001));
  localparam int TMR_W = 21;
  typedef enum logic {DOZE_IDLE, DOZE_WAIT} pcr_doze_e;
endpackage

// ### rtl/pcr_reg_if.sv
// register access path between frame engine and register bank
`timescale 1ns/1ps
interface pcr_reg_if;
  import pcr_pkg::*;
  logic wr_stb;
  logic [REG_W-1:0] wdata;
  logic [REG_W-1:0] rdata;
  logic [4:0] station_address;
  modport engine (output wr_stb, output wdata, input rdata, input station_address);
  modport bank (input wr_stb, input wdata, output rdata, output station_address);
endinterface

// ### rtl/pcr_smi_frame.sv
// serial management frame engine, mdc sampled on the system clock
`timescale 1ns/1ps
module pcr_smi_frame (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  pcr_reg_if.engine ri
);
  import pcr_pkg::*;

  typedef struct packed {
    logic [2:0] mdc_s;
    logic [2:0] mdio_s;
    logic mdc_q;
    logic mdio_q;
    pcr_smi_e st;
    logic [5:0] pre_cnt;
    logic [4:0] bit_cnt;
    logic [12:0] hdr;
    logic rd;
    logic mine;
    logic [REG_W-1:0] sh;
    logic oe;
    logic dout;
    logic wr_stb;
  } pcr_smi_s;

  pcr_smi_s r;
  pcr_smi_s next_r;
  logic rise;
  logic bit_in;
  logic [12:0] nh;

  // ==========================================================
  // frame sequencing
  always_comb begin
    next_r = r;
    next_r.wr_stb = 1'b0;
    next_r.mdc_s = {r.mdc_s[1:0], mdc};
    next_r.mdio_s = {r.mdio_s[1:0], mdio_in};
    // only the second and third stages are looked at
    if (r.mdc_s[1] == r.mdc_s[2]) begin
      next_r.mdc_q = r.mdc_s[2];
    end
    if (r.mdio_s[1] == r.mdio_s[2]) begin
      next_r.mdio_q = r.mdio_s[2];
    end
    rise = (r.mdc_s[1] == r.mdc_s[2]) && r.mdc_s[2] && !r.mdc_q;
    bit_in = next_r.mdio_q;
    nh = {r.hdr[11:0], bit_in};
    if (rise) begin
      unique case (r.st)
        SMI_PRE: begin
          if (bit_in) begin
            if (r.pre_cnt != PRE_MIN) begin
              next_r.pre_cnt = r.pre_cnt + 6'h1;
            end
          end else if (r.pre_cnt == PRE_MIN) begin
            next_r.st = SMI_HDR;
            next_r.bit_cnt = 5'h0;
          end else begin
            next_r.pre_cnt = 6'h0;
          end
        end
        SMI_HDR: begin
          next_r.hdr = nh;
          next_r.bit_cnt = r.bit_cnt + 5'h1;
          if (r.bit_cnt == HDR_LAST) begin
            next_r.pre_cnt = 6'h0;
            next_r.bit_cnt = 5'h0;
            next_r.rd = nh[11:10] == OP_RD;
            next_r.mine = nh[9:5] == ri.station_address && nh[4:0] == PCR_REG_ADDR;
            next_r.sh = ri.rdata;
            if (nh[12] && (nh[11:10] == OP_RD || nh[11:10] == OP_WR)) begin
              next_r.st = SMI_TA;
            end else begin
              next_r.st = SMI_PRE;
            end
          end
        end
        SMI_TA: begin
          next_r.bit_cnt = r.bit_cnt + 5'h1;
          if (r.bit_cnt == 5'h0) begin
            next_r.oe = r.rd && r.mine;
            next_r.dout = 1'b0;
          end else begin
            next_r.st = SMI_DATA;
            next_r.bit_cnt = 5'h0;
            if (r.rd) begin
              next_r.dout = r.sh[REG_W-1];
              next_r.sh = {r.sh[REG_W-2:0], 1'b0};
            end
          end
        end
        SMI_DATA: begin
          next_r.bit_cnt = r.bit_cnt + 5'h1;
          if (r.rd) begin
            next_r.dout = r.sh[REG_W-1];
            next_r.sh = {r.sh[REG_W-2:0], 1'b0};
          end else begin
            next_r.sh = {r.sh[REG_W-2:0], bit_in};
          end
          if (r.bit_cnt == DATA_LAST) begin
            next_r.oe = 1'b0;
            next_r.dout = 1'b0;
            next_r.wr_stb = !r.rd && r.mine;
            next_r.st = SMI_PRE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign mdio_out = r.dout;
  assign mdio_oe = r.oe;
  assign ri.wr_stb = r.wr_stb;
  assign ri.wdata = r.sh;
endmodule // pcr_smi_frame

// ### rtl/pcr_config_two.sv
// second phy configuration register with the logic it steers
//
// Notes on behaviour
// - The five-bit station address reads at bits 15:11 and serves frame matching.
// - Field 10:9 picks an averaging window of 32, 64, 128 or 256 symbols and resets to 01.
// - Field 8:6 picks the warning class, 000 turns warning off, and it resets to 001.
// - Field 5:3 picks the fail class, 000 turns the fail check off and is the reset value.
// - Bit 2 set allows packets up to 16 kB and is the reset value, cleared limits them to 4 kB.
// - Field 1:0 sets the doze request time-out of 0.4, 1, 4 or 16 ms and resets to 01.
// - A sticky warning flag is set when the averaged ratio is below the warning level while link is good.
// - When the doze request timer expires the block leaves doze request and sets a sticky abort flag.
`timescale 1ns/1ps
module pcr_config_two #(
  parameter int DOZE_CYC_00 = pcr_pkg::DOZE_CYC_0,
  parameter int DOZE_CYC_01 = pcr_pkg::DOZE_CYC_1,
  parameter int DOZE_CYC_10 = pcr_pkg::DOZE_CYC_2,
  parameter int DOZE_CYC_11 = pcr_pkg::DOZE_CYC_3
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [1:0] strap_addr,
  input wire logic [pcr_pkg::SNR_W-1:0] snr_sample,
  input wire logic snr_valid,
  input wire logic link_good,
  input wire logic warn_clear,
  input wire logic doze_enter,
  input wire logic doze_leave,
  input wire logic abort_clear,
  output logic [4:0] station_address,
  output logic [1:0] noise_ratio_window,
  output logic [2:0] warn_threshold_select,
  output logic [2:0] fail_threshold_select,
  output logic jumbo_enable,
  output logic [1:0] doze_request_timeout,
  output logic [pcr_pkg::SNR_W-1:0] snr_average,
  output logic snr_fail,
  output logic quality_warning_flag,
  output logic doze_active,
  output logic sleep_abort_flag
);
  import pcr_pkg::*;

  // ==========================================================
  // elaboration checks
  if (DOZE_CYC_00 < 1 || DOZE_CYC_00 >= (1 << TMR_W)) begin : g_chk0
    $error("doze count 00 out of range");
  end
  if (DOZE_CYC_01 < 1 || DOZE_CYC_01 >= (1 << TMR_W)) begin : g_chk1
    $error("doze count 01 out of range");
  end
  if (DOZE_CYC_10 < 1 || DOZE_CYC_10 >= (1 << TMR_W)) begin : g_chk2
    $error("doze count 10 out of range");
  end
  if (DOZE_CYC_11 < 1 || DOZE_CYC_11 >= (1 << TMR_W)) begin : g_chk3
    $error("doze count 11 out of range");
  end

  typedef struct packed {
    logic [5:0] strap_s;
    logic strap_taken;
    logic [1:0] strap_fill;
    logic [1:0] strap_lo;
    logic [1:0] win;
    logic [2:0] warn;
    logic [2:0] fail;
    logic jumbo;
    logic [1:0] doze_sel;
    logic [ACC_W-1:0] acc;
    logic [8:0] cnt;
    logic [SNR_W-1:0] avg;
    logic avg_ok;
    logic warn_flag;
    logic fail_lvl;
    pcr_doze_e doze;
    logic [TMR_W-1:0] tmr;
    logic abort_flag;
  } pcr_cfg_s;

  pcr_cfg_s r;
  pcr_cfg_s next_r;
  pcr_reg_if ri ();
  logic [ACC_W-1:0] sum;
  logic warn_set;
  logic expire;

  // ==========================================================
  // helpers
  function automatic logic [SNR_W-1:0] snr_limit(input logic [2:0] code);
    snr_limit = '0;
    if (code != 3'h0) begin
      snr_limit = SNR_LIMITS[{code - 3'h1, 3'h0} +: SNR_W];
    end
  endfunction

  function automatic logic [8:0] win_len(input logic [1:0] code);
    win_len = WIN_BASE << code;
  endfunction

  function automatic logic [SNR_W-1:0] avg_of(input logic [ACC_W-1:0] s, input logic [1:0] code);
    logic [ACC_W-1:0] q;
    q = s >> (WIN_SHIFT + {2'h0, code});
    avg_of = q[SNR_W-1:0];
  endfunction

  function automatic logic [TMR_W-1:0] doze_limit(input logic [1:0] code);
    unique case (code)
      2'h0: doze_limit = TMR_W'(DOZE_CYC_00 - 1);
      2'h1: doze_limit = TMR_W'(DOZE_CYC_01 - 1);
      2'h2: doze_limit = TMR_W'(DOZE_CYC_10 - 1);
      2'h3: doze_limit = TMR_W'(DOZE_CYC_11 - 1);
    endcase
  endfunction

  // ==========================================================
  // frame engine
  pcr_smi_frame u_smi (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .ri(ri.engine)
  );

  assign ri.rdata = {station_address, r.win, r.warn, r.fail, r.jumbo, r.doze_sel};
  assign ri.station_address = station_address;

  // ==========================================================
  // register and monitor state
  always_comb begin
    next_r = r;
    warn_set = 1'b0;
    expire = 1'b0;
    next_r.strap_s = {r.strap_s[3:0], strap_addr};
    if (r.strap_fill != 2'h3) begin
      next_r.strap_fill = r.strap_fill + 2'h1;
    end
    // reset zeros must leave all three stages before the catch
    if (!r.strap_taken && r.strap_fill == 2'h3 && r.strap_s[3:2] == r.strap_s[5:4]) begin
      next_r.strap_taken = 1'b1;
      next_r.strap_lo = r.strap_s[5:4];
    end
    sum = r.acc + {{(ACC_W - SNR_W){1'b0}}, snr_sample};
    if (snr_valid) begin
      if (r.cnt == win_len(r.win) - 9'h1) begin
        next_r.avg = avg_of(sum, r.win);
        next_r.avg_ok = 1'b1;
        next_r.acc = '0;
        next_r.cnt = 9'h0;
      end else begin
        next_r.acc = sum;
        next_r.cnt = r.cnt + 9'h1;
      end
    end
    if (ri.wr_stb) begin
      next_r.win = ri.wdata[WIN_LSB +: 2];
      next_r.warn = ri.wdata[WARN_LSB +: 3];
      next_r.fail = ri.wdata[FAIL_LSB +: 3];
      next_r.jumbo = ri.wdata[JUMBO_BIT];
      next_r.doze_sel = ri.wdata[DOZE_LSB +: 2];
      // a new window restarts the running sum
      next_r.acc = '0;
      next_r.cnt = 9'h0;
    end
    warn_set = r.avg_ok && link_good && r.warn != 3'h0 && r.avg < snr_limit(r.warn);
    next_r.fail_lvl = r.avg_ok && r.fail != 3'h0 && r.avg < snr_limit(r.fail);
    unique case (r.doze)
      DOZE_IDLE: begin
        if (doze_enter) begin
          next_r.doze = DOZE_WAIT;
          next_r.tmr = doze_limit(r.doze_sel);
        end
      end
      DOZE_WAIT: begin
        if (doze_leave) begin
          next_r.doze = DOZE_IDLE;
        end else if (r.tmr == '0) begin
          next_r.doze = DOZE_IDLE;
          expire = 1'b1;
        end else begin
          next_r.tmr = r.tmr - TMR_W'(1);
        end
      end
    endcase
    // sticky warning, set beats clear; entering doze clears it
    next_r.warn_flag = (r.warn_flag && !warn_clear && !doze_enter) || warn_set;
    next_r.abort_flag = (r.abort_flag && !abort_clear) || expire;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      r <= '0;
      r.win <= WIN_RST;
      r.warn <= WARN_RST;
      r.fail <= FAIL_RST;
      r.jumbo <= JUMBO_RST;
      r.doze_sel <= DOZE_RST;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // outputs
  // fixed high bits
  assign station_address = {ADDR_HIGH, r.strap_lo};
  assign noise_ratio_window = r.win;
  assign warn_threshold_select = r.warn;
  assign fail_threshold_select = r.fail;
  // 1 = 16 kB, 0 = 4 kB
  assign jumbo_enable = r.jumbo;
  assign doze_request_timeout = r.doze_sel;
  assign snr_average = r.avg;
  assign snr_fail = r.fail_lvl;
  assign quality_warning_flag = r.warn_flag;
  assign doze_active = r.doze == DOZE_WAIT;
  assign sleep_abort_flag = r.abort_flag;
endmodule // pcr_config_two

// ### dv/pcr_sva.sv
// port assertions for the second phy configuration register
`timescale 1ns/1ps
module pcr_sva
  import pcr_pkg::*;
#(
  parameter int DOZE_CYC_00 = 5,
  parameter int DOZE_CYC_01 = 10,
  parameter int DOZE_CYC_10 = 20,
  parameter int DOZE_CYC_11 = 40
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic link_good,
  input wire logic warn_clear,
  input wire logic doze_enter,
  input wire logic doze_leave,
  input wire logic [4:0] station_address,
  input wire logic [1:0] noise_ratio_window,
  input wire logic [2:0] warn_threshold_select,
  input wire logic [2:0] fail_threshold_select,
  input wire logic jumbo_enable,
  input wire logic [1:0] doze_request_timeout,
  input wire logic [SNR_W-1:0] snr_average,
  input wire logic snr_fail,
  input wire logic quality_warning_flag,
  input wire logic doze_active,
  input wire logic sleep_abort_flag
);
  // ==========================================================
  // helpers
  logic [20:0] act_cnt;
  logic warn_hit;
  logic avg_seen;
  int lim;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) act_cnt <= '0;
    else act_cnt <= doze_active ? act_cnt + 21'h1 : '0;
  end
  // no warning before the first window has closed
  always_ff @(posedge ref_clk) begin
    if (sys_rst) avg_seen <= 1'b0;
    else avg_seen <= avg_seen || snr_average != '0;
  end
  always_comb begin
    case (doze_request_timeout)
      2'h0: lim = DOZE_CYC_00;
      2'h1: lim = DOZE_CYC_01;
      2'h2: lim = DOZE_CYC_10;
      default: lim = DOZE_CYC_11;
    endcase
  end
  assign warn_hit = (avg_seen || snr_average != '0) && link_good && warn_threshold_select != 3'h0
    && snr_average < SNR_LIMITS[8*(warn_threshold_select-3'h1) +: 8];
  // ==========================================================
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_turn;
    !mdio_out ##1 mdio_oe [*8];
  endsequence
  sequence s_wake;
    !doze_active && sleep_abort_flag;
  endsequence
  addr_fixed_a: assert property (station_address[4:2] == ADDR_HIGH)
    else $error("address high bits wrong");
  addr_once_a: assert property ($changed(station_address) |->
    $past(station_address[1:0]) == 2'h0) else $error("address changed twice");
  reset_dflt_a: assert property ($fell(sys_rst) |-> {noise_ratio_window,
    warn_threshold_select, fail_threshold_select, jumbo_enable, doze_request_timeout}
    == {WIN_RST, WARN_RST, FAIL_RST, JUMBO_RST, DOZE_RST}) else $error("bad defaults");
  field_write_a: assert property ($changed({noise_ratio_window,
    warn_threshold_select, fail_threshold_select, jumbo_enable, doze_request_timeout})
    |-> $past(mdc, 3)) else $error("field moved without a write");
  turn_drive_a: assert property ($rose(mdio_oe) |-> s_turn)
    else $error("turnaround drive wrong");
  doze_start_a: assert property (doze_enter && !doze_active |=> doze_active)
    else $error("doze not entered");
  doze_hold_a: assert property (doze_active && !doze_leave && act_cnt < lim - 1
    |=> doze_active) else $error("doze ended early");
  doze_expire_a: assert property (doze_active && !doze_leave && act_cnt == lim - 1
    |=> s_wake) else $error("doze expiry wrong");
  warn_set_a: assert property (warn_hit |=> quality_warning_flag)
    else $error("warning not set");
  warn_cause_a: assert property ($rose(quality_warning_flag) |-> $past(warn_hit))
    else $error("warning without cause");
  warn_keep_a: assert property (quality_warning_flag && !warn_clear && !doze_enter
    |=> quality_warning_flag) else $error("warning lost");
  fail_off_a: assert property (fail_threshold_select == 3'h0
    && $past(fail_threshold_select) == 3'h0 |-> !snr_fail) else $error("fail while off");
endmodule // pcr_sva

// ### dv/pcr_smi_master.sv
// station management controller model driving management frames
`timescale 1ns/1ps
module pcr_smi_master (
  input wire logic ref_clk,
  output logic mdc,
  output logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe
);
  logic drv;
  logic dv;
  // released line floats to the pull-up level
  assign mdio_in = mdio_oe ? mdio_out : (drv ? dv : 1'b1);
  initial begin
    mdc = 1'b0;
    drv = 1'b0;
    dv = 1'b1;
  end
  // ==========================================================
  // one mdc period, 9 ref_clk low and 8 high, sample before fall
  task automatic bitc(input logic d, input logic en, output logic s);
    @(posedge ref_clk) drv <= en;
    dv <= d;
    repeat (8) @(posedge ref_clk);
    mdc <= 1'b1;
    repeat (8) @(posedge ref_clk);
    s = mdio_in;
    mdc <= 1'b0;
  endtask
  task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
    input logic [15:0] wd, output logic [15:0] rdat);
    logic [63:0] f;
    logic s;
    f = {32'hffffffff, 2'b01, rd ? 2'b10 : 2'b01, pa, ra, 2'b10, wd};
    rdat = 16'h0;
    for (int i = 63; i >= 0; i--) begin
      bitc(f[i], !(rd && i < 18), s);
      if (i < 17 && i > 0) rdat[i-1] = s;
    end
    drv <= 1'b0;
  endtask
endmodule // pcr_smi_master

// ### dv/tb_top.sv
// self-checking bench for the second configuration register
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module tb_top;
  localparam logic [4:0] PA = 5'h06;
  logic ref_clk, sys_rst, mdc, mdio_in, mdio_out, mdio_oe;
  logic snr_valid, link_good, warn_clear, doze_enter, doze_leave, abort_clear;
  logic [7:0] snr_sample, snr_average;
  logic [4:0] station_address;
  logic [1:0] noise_ratio_window, doze_request_timeout;
  logic [2:0] warn_threshold_select, fail_threshold_select;
  logic jumbo_enable, snr_fail, quality_warning_flag, doze_active, sleep_abort_flag;
  logic [15:0] rd;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int lim[4] = '{5, 10, 20, 40};
  // ==========================================================
  // dut and controller model
  pcr_config_two #(.DOZE_CYC_00(5), .DOZE_CYC_01(10), .DOZE_CYC_10(20),
    .DOZE_CYC_11(40)) u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .strap_addr(2'b10),
    .snr_sample(snr_sample), .snr_valid(snr_valid), .link_good(link_good),
    .warn_clear(warn_clear), .doze_enter(doze_enter), .doze_leave(doze_leave),
    .abort_clear(abort_clear), .station_address(station_address),
    .noise_ratio_window(noise_ratio_window), .warn_threshold_select(warn_threshold_select),
    .fail_threshold_select(fail_threshold_select), .jumbo_enable(jumbo_enable),
    .doze_request_timeout(doze_request_timeout), .snr_average(snr_average),
    .snr_fail(snr_fail), .quality_warning_flag(quality_warning_flag),
    .doze_active(doze_active), .sleep_abort_flag(sleep_abort_flag));
  pcr_smi_master u_smi (.ref_clk(ref_clk), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // helpers
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // sized for about 54 frames of 1100 cycles, twice the 27 frames the bench sends
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    u_smi.frame(1'b0, PA, ra, d, rd);
  endtask
  task automatic chk_rd(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] e);
    u_smi.frame(1'b1, pa, ra, 16'h0, rd);
    `CHK(rd, e)
  endtask
  task automatic feed(input int n, input logic [7:0] v);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk) snr_valid <= 1'b1;
      snr_sample <= v;
    end
    @(posedge ref_clk) snr_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_fields();
    logic [15:0] w;
    chk_rd(PA, 5'h13, 16'h3245);
    for (int i = 0; i < 8; i++) begin
      w = {5'h1f, i[1:0], i[2:0], i[2:0], i[0], i[1:0]};
      wr(5'h13, w);
      chk_rd(PA, 5'h13, {PA, w[10:0]});
      `CHK({noise_ratio_window, warn_threshold_select, fail_threshold_select, jumbo_enable, doze_request_timeout}, w[10:0])
    end
    wr(5'h14, 16'h0000);
    chk_rd(PA, 5'h13, {PA, 11'h7ff});
    chk_rd(PA, 5'h14, 16'hffff);
    chk_rd(5'h05, 5'h13, 16'hffff);
    $display("test fields done");
  endtask
  task automatic t_doze();
    int n;
    for (int t = 0; t < 4; t++) begin
      wr(5'h13, {3'h0, 9'h0a0, 2'h1, t[1:0]});
      @(posedge ref_clk) doze_enter <= 1'b1;
      @(posedge ref_clk) doze_enter <= 1'b0;
      #1 n = 0;
      while (doze_active === 1'b1 && n < 100) begin
        n++;
        @(posedge ref_clk);
        #1;
      end
      `CHK(n, lim[t])
      `CHK(sleep_abort_flag, 1'b1)
      @(posedge ref_clk) abort_clear <= 1'b1;
      @(posedge ref_clk) abort_clear <= 1'b0;
      #1 `CHK(sleep_abort_flag, 1'b0)
    end
    // left early: no expiry, no abort flag
    @(posedge ref_clk) doze_enter <= 1'b1;
    @(posedge ref_clk) doze_enter <= 1'b0;
    doze_leave <= 1'b1;
    @(posedge ref_clk) doze_leave <= 1'b0;
    repeat (60) @(posedge ref_clk);
    #1 `CHK({doze_active, sleep_abort_flag}, 2'b00)
    $display("test doze done");
  endtask
  task automatic t_warn();
    wr(5'h13, 16'h004d);
    @(posedge ref_clk) link_good <= 1'b1;
    feed(32, 8'h08);
    `CHK(snr_average, 8'h08)
    `CHK({quality_warning_flag, snr_fail}, 2'b11)
    @(posedge ref_clk) link_good <= 1'b0;
    warn_clear <= 1'b1;
    @(posedge ref_clk) warn_clear <= 1'b0;
    #1 `CHK(quality_warning_flag, 1'b0)
    wr(5'h13, 16'h024d);
    feed(32, 8'h00);
    feed(32, 8'h40);
    `CHK({snr_average, quality_warning_flag, snr_fail}, 10'h080)
    $display("test warn done");
  endtask
  initial begin
    sys_rst = 1'b1;
    {snr_valid, link_good, warn_clear, doze_enter, doze_leave, abort_clear} = 6'h0;
    snr_sample = 8'h00;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 `CHK(station_address, PA)
    t_fields();
    t_doze();
    t_warn();
    test_done();
  end
endmodule // tb_top
bind pcr_config_two pcr_sva #(.DOZE_CYC_00(DOZE_CYC_00), .DOZE_CYC_01(DOZE_CYC_01),
  .DOZE_CYC_10(DOZE_CYC_10), .DOZE_CYC_11(DOZE_CYC_11)) u_sva (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
  .link_good(link_good), .warn_clear(warn_clear), .doze_enter(doze_enter),
  .doze_leave(doze_leave), .station_address(station_address),
  .noise_ratio_window(noise_ratio_window), .warn_threshold_select(warn_threshold_select),
  .fail_threshold_select(fail_threshold_select), .jumbo_enable(jumbo_enable),
  .doze_request_timeout(doze_request_timeout), .snr_average(snr_average),
  .snr_fail(snr_fail), .quality_warning_flag(quality_warning_flag),
  .doze_active(doze_active), .sleep_abort_flag(sleep_abort_flag));
